// ---- src/cfg_pin_pkg.sv ----
// shared constants and types for the configuration pin controller
package cfg_pin_pkg;

	localparam int unsigned CLK_HZ         = 100_000_000;
	// internal memory clear time while init is driven low
	localparam int unsigned CLEAR_TIME_NS  = 1000;
	localparam int unsigned CLEAR_CYCLES   =
		(CLEAR_TIME_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
	// pacing of the loader, the read strobe and readback
	localparam int unsigned TICK_DIV       = 4;

	localparam int unsigned FIFO_WIDTH     = 8;
	localparam int unsigned FIFO_DEPTH     = 16;

	// register byte addresses
	localparam logic [7:0] ADDR_CTRL       = 8'h00;
	localparam logic [7:0] ADDR_STATUS     = 8'h04;
	localparam logic [7:0] ADDR_LENGTH     = 8'h08;
	localparam logic [7:0] ADDR_COUNT      = 8'h0c;
	localparam logic [7:0] ADDR_RB_FRAMES  = 8'h10;

	// control register fields
	localparam int unsigned CTRL_FORCE_DONE = 0;
	localparam int unsigned CTRL_BSCAN_SEL  = 1;
	localparam int unsigned CTRL_RB_EN      = 2;
	localparam int unsigned CTRL_HOST_IRQ   = 3;
	localparam int unsigned CTRL_PLL_USED   = 4;
	localparam logic [4:0]  CTRL_RESET      = 5'h00;
	localparam logic [15:0] LENGTH_RESET    = 16'h0000;
	localparam logic [7:0]  RB_FRAMES_RESET = 8'h01;

	// status register field positions
	localparam int unsigned STAT_STATE_LSB = 0;
	localparam int unsigned STAT_MODE_LSB  = 8;
	localparam int unsigned STAT_ERR       = 12;
	localparam int unsigned STAT_RB_BUSY   = 13;
	localparam int unsigned STAT_READY     = 14;

	localparam logic [1:0] RESP_OKAY       = 2'h0;
	localparam logic [1:0] RESP_DECERR     = 2'h3;

	// configuration mode codes carried on the mode select pins
	localparam logic [3:0] MODE_MASTER_SER = 4'h0;
	localparam logic [3:0] MODE_MASTER_PAR = 4'h1;
	localparam logic [3:0] MODE_SLAVE_SER  = 4'h2;
	localparam logic [3:0] MODE_SLAVE_PAR  = 4'h3;
	localparam logic [3:0] MODE_ASYNC_PERI = 4'h4;
	localparam logic [3:0] MODE_HOST_PORT  = 4'h5;
	localparam logic [3:0] MODE_TEST_PORT  = 4'h6;

	typedef enum logic [3:0] {
		ST_CLEAR  = 4'b0001,
		ST_WAIT   = 4'b0010,
		ST_CONFIG = 4'b0100,
		ST_DONE   = 4'b1000
	} cfg_state_t;

	// raw pin inputs, passed through the synchroniser as one word
	typedef struct packed {
		logic       init_n;
		logic [3:0] mode_sel;
		logic       tck;
		logic       tms;
		logic       tdi;
		logic       rb_trig_n;
		logic       select_low_active;
		logic       select_high_active;
		logic       rd_n;
		logic       wr_n;
		logic [7:0] data;
	} pins_in_t;

	// pull-up and high impedance controls active during configuration
	typedef struct packed {
		logic mode_pullup;
		logic pll_ref_clock_pins_hiz;
		logic pll_ref_clock_pins_pullup;
		logic test_pullup;
	} pullups_t;

	// pins handed back to user I/O after configuration
	typedef struct packed {
		logic mode_pins;
		logic ready_pin;
		logic pll_ref_clock_pins;
		logic test_pins;
		logic select_pins;
	} user_io_t;

endpackage : cfg_pin_pkg

// ---- src/cfg_byte_fifo.sv ----
// byte fifo between the configuration data pins and the loader
`timescale 1ns/100ps
module cfg_byte_fifo #(
	parameter int unsigned WIDTH = 8,
	parameter int unsigned DEPTH = 16
) (
	input  wire logic             clock_i,
	input  wire logic             rst_i,
	input  wire logic             in_valid_i,
	input  wire logic [WIDTH-1:0] in_data_i,
	output logic                  in_ready_o,
	output logic                  out_valid_o,
	output logic [WIDTH-1:0]      out_data_o,
	input  wire logic             out_ready_i
);
	localparam int unsigned AW = $clog2(DEPTH);

	generate
		if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_chk
			$error("cfg_byte_fifo: depth must be a power of two >= 2");
		end
	endgenerate

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr;
	logic [AW-1:0]    rd_ptr;
	logic [AW:0]      used;
	logic             push;
	logic             pop;

	assign push = in_valid_i && in_ready_o;
	// the output register is refilled whenever it is empty or drained
	assign pop  = (used != '0) && (!out_valid_o || out_ready_i);

	always_ff @(posedge clock_i) begin
		if (push) begin
			mem[wr_ptr] <= in_data_i;
		end
	end

	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			wr_ptr     <= '0;
			rd_ptr     <= '0;
			used       <= '0;
			in_ready_o <= 1'b1;
		end else begin
			if (push) begin
				wr_ptr <= wr_ptr + 1'b1;
			end
			if (pop) begin
				rd_ptr <= rd_ptr + 1'b1;
			end
			used       <= used + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
			in_ready_o <= (used + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop})
				< (AW+1)'(DEPTH);
		end
	end

	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			out_valid_o <= 1'b0;
			out_data_o  <= '0;
		end else if (pop) begin
			out_valid_o <= 1'b1;
			out_data_o  <= mem[rd_ptr];
		end else if (out_ready_i) begin
			out_valid_o <= 1'b0;
		end
	end

endmodule : cfg_byte_fifo

// ---- src/config_port_pin_control.sv ----
// configuration and test pin control with an AXI4-Lite register slave
//
// The placing of the registers and the AXI4-Lite slave port were chosen for this implementation.
`timescale 1ns/100ps
module config_port_pin_control
	import cfg_pin_pkg::*;
#(
	parameter int unsigned FIFO_W = FIFO_WIDTH,
	parameter int unsigned FIFO_D = FIFO_DEPTH
) (
	input  wire logic        clock_i,
	input  wire logic        rst_i,
	// AXI4-Lite register slave
	input  wire logic [7:0]  s_axi_awaddr_i,
	input  wire logic        s_axi_awvalid_i,
	output logic             s_axi_awready_o,
	input  wire logic [31:0] s_axi_wdata_i,
	input  wire logic [3:0]  s_axi_wstrb_i,
	input  wire logic        s_axi_wvalid_i,
	output logic             s_axi_wready_o,
	output logic [1:0]       s_axi_bresp_o,
	output logic             s_axi_bvalid_o,
	input  wire logic        s_axi_bready_i,
	input  wire logic [7:0]  s_axi_araddr_i,
	input  wire logic        s_axi_arvalid_i,
	output logic             s_axi_arready_o,
	output logic [31:0]      s_axi_rdata_o,
	output logic [1:0]       s_axi_rresp_o,
	output logic             s_axi_rvalid_o,
	input  wire logic        s_axi_rready_i,
	// internal initialisation results
	input  wire logic        ram_init_fail_i,
	input  wire logic        core_init_fail_i,
	// configuration and test pins
	input  wire pins_in_t    pins_i,
	output logic             init_n_o,
	output logic             init_n_oe_n_o,
	output logic [7:0]       data_o,
	output logic             data_oe_n_o,
	output logic             ready_o,
	output logic             cfg_irq_n_o,
	output logic             rd_data_tdo_o,
	output logic             done_o,
	output pullups_t         pullups_o,
	output user_io_t         user_io_o,
	output cfg_state_t       state_o
);
	generate
		if (FIFO_W != 8 || FIFO_D < 2) begin : g_chk
			$error("config_port_pin_control: fifo must be 8 bits, depth >= 2");
		end
	endgenerate

	localparam int unsigned CLR_W = $clog2(CLEAR_CYCLES + 1);
	localparam int unsigned TCK_W = $clog2(TICK_DIV);

	// pins are asynchronous; only the second and third stages are read
	pins_in_t pin_meta;
	pins_in_t pin_sync;
	pins_in_t pin_prev;

	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			pin_meta <= '1;
			pin_sync <= '1;
			pin_prev <= '1;
		end else begin
			pin_meta <= pins_i;
			pin_sync <= pin_meta;
			pin_prev <= pin_sync;
		end
	end

	logic init_rise;
	logic trig_fall;
	logic tck_rise;
	logic wr_fall;
	logic selected;
	assign init_rise = pin_sync.init_n && !pin_prev.init_n;
	assign trig_fall = !pin_sync.rb_trig_n && pin_prev.rb_trig_n;
	assign tck_rise  = pin_sync.tck && !pin_prev.tck;
	assign wr_fall   = !pin_sync.wr_n && pin_prev.wr_n;
	assign selected  = !pin_sync.select_low_active
		&& pin_sync.select_high_active;

	// slow enable for the loader, read strobe and readback
	logic [TCK_W-1:0] div_cnt;
	logic             tick;
	assign tick = (div_cnt == TCK_W'(TICK_DIV - 1));

	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			div_cnt <= '0;
		end else begin
			div_cnt <= tick ? '0 : div_cnt + 1'b1;
		end
	end

	// register file
	logic [4:0]  ctrl;
	logic [15:0] length;
	logic [7:0]  rb_frames;
	logic [15:0] byte_count;
	logic [7:0]  signature;
	logic [3:0]  mode;
	cfg_state_t  state;
	logic        rb_busy;
	logic        fifo_in_ready;

	logic        wr_fire;
	logic [7:0]  aw_addr;
	logic [31:0] w_data;
	logic [3:0]  w_strb;

	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] val, input logic [3:0] strb);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				res[i*8 +: 8] = val[i*8 +: 8];
			end
		end
		return res;
	endfunction : merge

	function automatic logic mapped(input logic [7:0] addr);
		return addr == ADDR_CTRL || addr == ADDR_STATUS
			|| addr == ADDR_LENGTH || addr == ADDR_COUNT
			|| addr == ADDR_RB_FRAMES;
	endfunction : mapped

	// write channel: address and data taken in either order
	assign wr_fire = !s_axi_awready_o && !s_axi_wready_o && !s_axi_bvalid_o;

	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			s_axi_awready_o <= 1'b1;
			s_axi_wready_o  <= 1'b1;
			s_axi_bvalid_o  <= 1'b0;
			s_axi_bresp_o   <= RESP_OKAY;
			aw_addr         <= '0;
			w_data          <= '0;
			w_strb          <= '0;
		end else begin
			if (s_axi_awvalid_i && s_axi_awready_o) begin
				s_axi_awready_o <= 1'b0;
				aw_addr         <= s_axi_awaddr_i;
			end
			if (s_axi_wvalid_i && s_axi_wready_o) begin
				s_axi_wready_o <= 1'b0;
				w_data         <= s_axi_wdata_i;
				w_strb         <= s_axi_wstrb_i;
			end
			if (wr_fire) begin
				s_axi_bvalid_o <= 1'b1;
				s_axi_bresp_o  <= mapped(aw_addr) ? RESP_OKAY : RESP_DECERR;
			end
			if (s_axi_bvalid_o && s_axi_bready_i) begin
				s_axi_bvalid_o  <= 1'b0;
				s_axi_awready_o <= 1'b1;
				s_axi_wready_o  <= 1'b1;
			end
		end
	end

	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			ctrl      <= CTRL_RESET;
			length    <= LENGTH_RESET;
			rb_frames <= RB_FRAMES_RESET;
		end else if (wr_fire) begin
			case (aw_addr)
				ADDR_CTRL: begin
					ctrl <= 5'(merge({27'h0, ctrl}, w_data, w_strb));
				end
				ADDR_LENGTH: begin
					length <= 16'(merge({16'h0, length}, w_data, w_strb));
				end
				ADDR_RB_FRAMES: begin
					rb_frames <= 8'(merge({24'h0, rb_frames}, w_data, w_strb));
				end
				default: begin
				end
			endcase
		end
	end

	logic [31:0] status_word;
	always_comb begin
		status_word = '0;
		status_word[STAT_STATE_LSB +: 4] = state;
		status_word[STAT_MODE_LSB +: 4]  = mode;
		status_word[STAT_ERR]            = ram_init_fail_i || core_init_fail_i;
		status_word[STAT_RB_BUSY]        = rb_busy;
		status_word[STAT_READY]          = fifo_in_ready;
	end

	// read channel answers one cycle after the address is taken
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			s_axi_arready_o <= 1'b1;
			s_axi_rvalid_o  <= 1'b0;
			s_axi_rdata_o   <= '0;
			s_axi_rresp_o   <= RESP_OKAY;
		end else if (s_axi_arvalid_i && s_axi_arready_o) begin
			s_axi_arready_o <= 1'b0;
			s_axi_rvalid_o  <= 1'b1;
			s_axi_rresp_o   <= mapped(s_axi_araddr_i) ? RESP_OKAY : RESP_DECERR;
			case (s_axi_araddr_i)
				ADDR_CTRL:      s_axi_rdata_o <= {27'h0, ctrl};
				ADDR_STATUS:    s_axi_rdata_o <= status_word;
				ADDR_LENGTH:    s_axi_rdata_o <= {16'h0, length};
				ADDR_COUNT:     s_axi_rdata_o <= {16'h0, byte_count};
				ADDR_RB_FRAMES: s_axi_rdata_o <= {24'h0, rb_frames};
				default:        s_axi_rdata_o <= '0;
			endcase
		end else if (s_axi_rvalid_o && s_axi_rready_i) begin
			s_axi_rvalid_o  <= 1'b0;
			s_axi_arready_o <= 1'b1;
		end
	end

	// configuration sequencer
	logic [CLR_W-1:0] clr_cnt;
	logic             load_done;
	logic             configuring;
	assign configuring = (state == ST_CONFIG);
	assign load_done   = ctrl[CTRL_FORCE_DONE]
		|| (length != '0 && byte_count == length);

	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			state   <= ST_CLEAR;
			clr_cnt <= '0;
			mode    <= MODE_MASTER_SER;
		end else begin
			case (state)
				ST_CLEAR: begin
					clr_cnt <= clr_cnt + 1'b1;
					if (clr_cnt == CLR_W'(CLEAR_CYCLES - 1)) begin
						state <= ST_WAIT;
					end
				end
				ST_WAIT: begin
					if (init_rise) begin
						mode  <= pin_sync.mode_sel;
						state <= ST_CONFIG;
					end
				end
				ST_CONFIG: begin
					if (load_done) begin
						state <= ST_DONE;
					end
				end
				ST_DONE: begin
				end
				default: begin
					state <= ST_CLEAR;
				end
			endcase
		end
	end

	// init pin is open drain: pulled low only while memory clears
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			init_n_o      <= 1'b0;
			init_n_oe_n_o <= 1'b0;
			done_o        <= 1'b0;
			state_o       <= ST_CLEAR;
		end else begin
			init_n_o      <= 1'b0;
			init_n_oe_n_o <= (state != ST_CLEAR);
			done_o        <= (state == ST_DONE);
			state_o       <= state;
		end
	end

	// byte path into the fifo
	logic       fifo_push;
	logic [7:0] fifo_din;
	logic       fifo_out_valid;
	logic [7:0] fifo_out_data;
	logic       fifo_pop;
	logic       strobe_phase;
	logic       is_async;
	logic       is_master_par;
	assign is_async      = configuring && mode == MODE_ASYNC_PERI;
	assign is_master_par = configuring && mode == MODE_MASTER_PAR;

	// master parallel fetch: strobe low one tick, sample on the next
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			strobe_phase <= 1'b0;
		end else if (!is_master_par) begin
			strobe_phase <= 1'b0;
		end else if (tick) begin
			strobe_phase <= !strobe_phase && fifo_in_ready && !load_done;
		end
	end

	always_comb begin
		fifo_push = 1'b0;
		fifo_din  = pin_sync.data;
		if (is_async) begin
			// a write strobe overrides a simultaneous read
			fifo_push = wr_fall && selected;
		end else if (is_master_par) begin
			fifo_push = tick && strobe_phase;
		end
	end

	cfg_byte_fifo #(
		.WIDTH (FIFO_W),
		.DEPTH (FIFO_D)
	) u_fifo (
		.clock_i     (clock_i),
		.rst_i       (rst_i),
		.in_valid_i  (fifo_push),
		.in_data_i   (fifo_din),
		.in_ready_o  (fifo_in_ready),
		.out_valid_o (fifo_out_valid),
		.out_data_o  (fifo_out_data),
		.out_ready_i (fifo_pop)
	);

	// loader drains one byte per tick and folds it into a signature
	assign fifo_pop = tick && configuring;

	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			byte_count <= '0;
			signature  <= '0;
		end else if (fifo_pop && fifo_out_valid) begin
			byte_count <= byte_count + 1'b1;
			signature  <= {signature[6:0], signature[7]} ^ fifo_out_data;
		end
	end

	// ready pin: byte space or read strobe
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			ready_o <= 1'b0;
		end else if (is_async) begin
			ready_o <= fifo_in_ready;
		end else if (is_master_par) begin
			ready_o <= !strobe_phase;
		end else begin
			ready_o <= 1'b0;
		end
	end

	// status read returns ready on bit 7
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			data_o      <= '0;
			data_oe_n_o <= 1'b1;
		end else begin
			data_o      <= {fifo_in_ready, 7'h00};
			data_oe_n_o <= !(is_async && selected && !pin_sync.rd_n
				&& pin_sync.wr_n);
		end
	end

	// error flag or host interrupt on the shared pin
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			cfg_irq_n_o <= 1'b1;
		end else if (mode == MODE_HOST_PORT && state != ST_WAIT
			&& state != ST_CLEAR) begin
			cfg_irq_n_o <= !ctrl[CTRL_HOST_IRQ];
		end else if (configuring) begin
			cfg_irq_n_o <= !(ram_init_fail_i || core_init_fail_i);
		end else begin
			cfg_irq_n_o <= 1'b1;
		end
	end

	// boundary scan: a one-bit bypass path loaded on rising test clock edges while tms is low
	logic scan_active;
	logic tdo_bit;
	// scan dies after configuration unless selected
	assign scan_active = (state != ST_DONE) || ctrl[CTRL_BSCAN_SEL];

	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			tdo_bit <= 1'b0;
		end else if (!scan_active) begin
			tdo_bit <= 1'b0;
		end else if (tck_rise && !pin_sync.tms) begin
			tdo_bit <= pin_sync.tdi;
		end
	end

	// readback: each frame is its address folded with the signature
	logic [7:0] rb_frame;
	logic [7:0] rb_shift;
	logic [2:0] rb_bit;

	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			rb_busy  <= 1'b0;
			rb_frame <= '0;
			rb_shift <= '0;
			rb_bit   <= '0;
		end else if (!rb_busy) begin
			// trigger edge starts at frame zero
			if (trig_fall && ctrl[CTRL_RB_EN] && state == ST_DONE) begin
				rb_busy  <= 1'b1;
				rb_frame <= '0;
				rb_shift <= signature;
				rb_bit   <= '0;
			end
		end else if (tick) begin
			rb_bit   <= rb_bit + 1'b1;
			rb_shift <= {1'b0, rb_shift[7:1]};
			if (rb_bit == 3'h7) begin
				rb_frame <= rb_frame + 1'b1;
				rb_shift <= (rb_frame + 1'b1) ^ signature;
				if (rb_frame + 1'b1 == rb_frames) begin
					rb_busy <= 1'b0;
				end
			end
		end
	end

	// scan output or readback data on the shared pin
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			rd_data_tdo_o <= 1'b0;
		end else if (ctrl[CTRL_BSCAN_SEL] || configuring) begin
			rd_data_tdo_o <= tdo_bit;
		end else begin
			rd_data_tdo_o <= rb_busy && rb_shift[0];
		end
	end

	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			pullups_o <= '1;
			user_io_o <= '0;
		end else begin
			pullups_o <= {4{state != ST_DONE}};
			// unclaimed pins return to user I/O
			user_io_o.mode_pins          <= (state == ST_DONE);
			user_io_o.ready_pin          <= (state == ST_DONE);
			user_io_o.pll_ref_clock_pins <= (state == ST_DONE)
				&& !ctrl[CTRL_PLL_USED];
			user_io_o.test_pins          <= (state == ST_DONE)
				&& !ctrl[CTRL_BSCAN_SEL];
			user_io_o.select_pins        <= (state == ST_DONE)
				&& mode != MODE_HOST_PORT;
		end
	end

endmodule : config_port_pin_control

// ---- testbench/cfg_pin_asserts.sv ----
// port assertions for the configuration pin controller
`timescale 1ns/100ps
module cfg_pin_asserts
	import cfg_pin_pkg::*;
(
	input  wire logic        clock_i,
	input  wire logic        rst_i,
	input  wire logic [7:0]  s_axi_araddr_i,
	input  wire logic        s_axi_arvalid_i,
	input  wire logic        s_axi_arready_o,
	input  wire logic [31:0] s_axi_rdata_o,
	input  wire logic [1:0]  s_axi_rresp_o,
	input  wire logic        s_axi_rvalid_o,
	input  wire logic        s_axi_rready_i,
	input  wire logic [1:0]  s_axi_bresp_o,
	input  wire logic        s_axi_bvalid_o,
	input  wire logic        s_axi_bready_i,
	input  wire logic [7:0]  data_o,
	input  wire logic        data_oe_n_o,
	input  wire logic        ready_o,
	input  wire logic        done_o,
	input  wire pullups_t    pullups_o,
	input  wire user_io_t    user_io_o,
	input  wire cfg_state_t  state_o
);
	default clocking @(posedge clock_i); endclocking
	default disable iff (rst_i);

	done_match_a: assert property (
		$stable(state_o) |-> done_o == (state_o == ST_DONE))
		else $error("done flag disagrees with state");
	cfg_pullups_a: assert property (
		$stable(state_o) && state_o != ST_DONE |-> pullups_o == 4'hf)
		else $error("pullups dropped before done");
	user_io_held_a: assert property (
		$stable(state_o) && state_o != ST_DONE |-> user_io_o == 5'h00)
		else $error("pins handed to user before done");
	ready_idle_a: assert property (
		$stable(state_o) && state_o inside {ST_CLEAR, ST_WAIT} |-> !ready_o)
		else $error("ready high before configuration");
	status_byte_a: assert property (
		!data_oe_n_o |-> data_o[6:0] == 7'h00)
		else $error("status byte low bits not zero");
	read_answer_a: assert property (
		s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
		else $error("read answer late");
	rdata_hold_a: assert property (
		s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o
			&& $stable(s_axi_rdata_o) && $stable(s_axi_rresp_o))
		else $error("read answer changed while waiting");
	bresp_hold_a: assert property (
		s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o
			&& $stable(s_axi_bresp_o))
		else $error("write answer changed while waiting");
	read_decode_a: assert property (
		s_axi_arvalid_i && s_axi_arready_o && s_axi_araddr_i > 8'h10
			|=> s_axi_rresp_o == RESP_DECERR)
		else $error("unmapped read not refused");
endmodule : cfg_pin_asserts

bind config_port_pin_control cfg_pin_asserts chk_u (.*);

// ---- testbench/cfg_host_model.sv ----
// configuration host and parallel memory on the far side of the pins
`timescale 1ns/100ps
module cfg_host_model
	import cfg_pin_pkg::*;
(
	input  wire logic       clock_i,
	input  wire logic       init_n_i,
	input  wire logic [3:0] mode_sel_i,
	input  wire logic       ready_i,
	input  wire logic [7:0] data_i,
	output pins_in_t        pins_o
);
	logic       sel = 0, drv = 0, rd_n = 1, wr_n = 1;
	logic [7:0] byte_q = 0, junk = 0, mem = 0;
	// tck, tms, tdi, readback trigger; idle high
	logic [3:0] scan_q = 4'hf;

	// released bus keeps changing so no stale byte looks valid
	always @(posedge clock_i)
		junk <= ~junk;
	always @(posedge ready_i)
		mem <= mem + 8'h01;
	assign pins_o = {init_n_i, mode_sel_i, scan_q, !sel, sel, rd_n, wr_n,
		drv ? byte_q : (!ready_i ? mem : junk)};

	task automatic write_byte(input logic [7:0] b);
		while (!ready_i) @(posedge clock_i);
		byte_q <= b;
		drv <= 1'b1;
		sel <= 1'b1;
		@(posedge clock_i);
		wr_n <= 1'b0;
		repeat (4) @(posedge clock_i);
		wr_n <= 1'b1;
		repeat (4) @(posedge clock_i);
		drv <= 1'b0;
		sel <= 1'b0;
		@(posedge clock_i);
	endtask : write_byte

	task automatic read_status(output logic [7:0] d);
		sel <= 1'b1;
		rd_n <= 1'b0;
		repeat (6) @(posedge clock_i);
		d = data_i;
		rd_n <= 1'b1;
		sel <= 1'b0;
		@(posedge clock_i);
	endtask : read_status
endmodule : cfg_host_model

// ---- testbench/testbench.sv ----
// self-checking bench for the configuration pin controller
`timescale 1ns/100ps
module testbench;
	import cfg_pin_pkg::*;
	logic        clock_i = 0, rst_i = 1;
	logic [7:0]  s_axi_awaddr_i = 0, s_axi_araddr_i = 0, data_o, d;
	logic [31:0] s_axi_wdata_i = 0, s_axi_rdata_o, seed = 32'h51a9ced0;
	logic [3:0]  s_axi_wstrb_i = 4'hf, mode_sel = 0;
	logic        s_axi_awvalid_i = 0, s_axi_wvalid_i = 0, s_axi_bready_i = 0;
	logic        s_axi_arvalid_i = 0, s_axi_rready_i = 0, init_n = 0;
	logic        ram_init_fail_i = 0, core_init_fail_i = 0;
	logic        s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o;
	logic        s_axi_arready_o, s_axi_rvalid_o, init_n_o, init_n_oe_n_o;
	logic        data_oe_n_o, ready_o, cfg_irq_n_o, rd_data_tdo_o, done_o;
	logic [1:0]  s_axi_bresp_o, s_axi_rresp_o;
	pullups_t    pullups_o;
	user_io_t    user_io_o;
	cfg_state_t  state_o;
	pins_in_t    pins_i;
	logic [33:0] exp_q[$];
	int          failures = 0, n_tests = 0, k, cyc = 0;
	logic [15:0] rb;

	always #5 clock_i = ~clock_i;
	// edges since reset release, to know the loader tick phase
	always @(posedge clock_i) cyc <= rst_i ? 0 : cyc + 1;

	config_port_pin_control dut_u (.*);
	cfg_host_model host_u (.clock_i(clock_i), .init_n_i(init_n),
		.mode_sel_i(mode_sel), .ready_i(ready_o),
		.data_i(data_oe_n_o ? ~data_o : data_o),
		.pins_o(pins_i));

	task automatic check(input string what, input logic [33:0] seen, exp);
		n_tests++;
		if (seen !== exp) begin
			failures++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : tally_and_finish

	task automatic rd(input logic [7:0] a, input logic [33:0] e);
		exp_q.push_back(e);
		s_axi_araddr_i <= a;
		s_axi_arvalid_i <= 1'b1;
		do @(posedge clock_i); while (!s_axi_arready_o);
		s_axi_arvalid_i <= 1'b0;
		@(posedge clock_i);
		s_axi_rready_i <= 1'b1;
		do @(posedge clock_i); while (!s_axi_rvalid_o);
		s_axi_rready_i <= 1'b0;
	endtask : rd

	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		logic aw, w;
		aw = 0;
		w = 0;
		s_axi_awaddr_i <= a;
		s_axi_wdata_i <= v;
		s_axi_awvalid_i <= 1'b1;
		s_axi_wvalid_i <= 1'b1;
		while (!(aw && w)) begin
			@(posedge clock_i);
			aw = aw || (s_axi_awvalid_i && s_axi_awready_o);
			w = w || (s_axi_wvalid_i && s_axi_wready_o);
			s_axi_awvalid_i <= !aw;
			s_axi_wvalid_i <= !w;
		end
		// bready rises one cycle after the handshake, on the same edge as bvalid, so the response never waits
		@(posedge clock_i);
		s_axi_bready_i <= 1'b1;
		do @(posedge clock_i); while (!s_axi_bvalid_o);
		check("bresp", s_axi_bresp_o, RESP_OKAY);
		s_axi_bready_i <= 1'b0;
	endtask : wr

	task automatic boot(input logic [3:0] m, input logic [15:0] len);
		rst_i <= 1'b1;
		init_n <= 1'b0;
		repeat (12) @(posedge clock_i);
		check("pullups", pullups_o, 4'hf);
		check("init oe", init_n_oe_n_o, 1'b0);
		rst_i <= 1'b0;
		repeat (110) @(posedge clock_i);
		check("state", state_o, ST_WAIT);
		check("init oe", init_n_oe_n_o, 1'b1);
		wr(ADDR_LENGTH, {16'h0, len});
		mode_sel <= m;
		init_n <= 1'b1;
		repeat (6) @(posedge clock_i);
		mode_sel <= ~m;
		rd(ADDR_STATUS, {RESP_OKAY, 17'h0, 1'b1, 2'b0, m, 8'h04});
	endtask : boot

	always @(posedge clock_i)
		if (s_axi_rvalid_o && s_axi_rready_i)
			check("rdata", {s_axi_rresp_o, s_axi_rdata_o}, exp_q.pop_front());

	initial begin
		repeat (5000) @(posedge clock_i);
		failures++;
		tally_and_finish();
	end

	initial begin
		boot(MODE_ASYNC_PERI, 16'd4);
		rd(ADDR_CTRL, 34'h0);
		rd(ADDR_RB_FRAMES, 34'h1);
		rd(8'h20, {RESP_DECERR, 32'h0});
		for (int i = 1; i < 4; i++) begin
			{core_init_fail_i, ram_init_fail_i} <= i[1:0];
			repeat (4) @(posedge clock_i);
			check("irq", cfg_irq_n_o, 1'b0);
		end
		{core_init_fail_i, ram_init_fail_i} <= 2'b00;
		repeat (4) @(posedge clock_i);
		check("irq", cfg_irq_n_o, 1'b1);
		check("ready", ready_o, 1'b1);
		host_u.read_status(d);
		check("status", d, 8'h80);
		repeat (4) host_u.write_byte(8'($random(seed)));
		for (int i = 0; i < 500 && !done_o; i++) @(posedge clock_i);
		repeat (2) @(posedge clock_i);
		check("done", done_o, 1'b1);
		rd(ADDR_COUNT, 34'h4);
		check("pullups", pullups_o, 4'h0);
		check("user io", user_io_o, 5'h1f);
		check("tdo", rd_data_tdo_o, 1'b0);
		wr(ADDR_RB_FRAMES, 32'h2);
		wr(ADDR_CTRL, 32'h4);
		// trigger lands on a loader tick so every bit stands four cycles
		while (cyc % TICK_DIV != 0) @(posedge clock_i);
		host_u.scan_q[0] <= 1'b0;
		repeat (6) @(posedge clock_i);
		for (int i = 0; i < 16; i++) begin
			rb[i] = rd_data_tdo_o;
			repeat (TICK_DIV) @(posedge clock_i);
		end
		// frames 0 and 1 differ only in their address bit
		check("readback", rb[7:0] ^ rb[15:8], 8'h01);
		wr(ADDR_CTRL, 32'h2);
		host_u.scan_q <= 4'b0010;
		repeat (4) @(posedge clock_i);
		host_u.scan_q <= 4'b1010;
		repeat (6) @(posedge clock_i);
		check("tdo", rd_data_tdo_o, 1'b1);
		wr(ADDR_CTRL, 32'h0);
		host_u.scan_q <= 4'b0010;
		repeat (4) @(posedge clock_i);
		host_u.scan_q <= 4'b1010;
		repeat (6) @(posedge clock_i);
		check("tdo off", rd_data_tdo_o, 1'b0);
		host_u.scan_q <= 4'hf;
		boot(MODE_MASTER_PAR, 16'd8);
		for (int i = 0; i < 20 && !ready_o; i++) @(posedge clock_i);
		for (int i = 0; i < 20 && ready_o; i++) @(posedge clock_i);
		k = 0;
		while (!ready_o && k < 9) begin
			@(posedge clock_i);
			k++;
		end
		check("strobe", k, 4);
		for (int i = 0; i < 500 && !done_o; i++) @(posedge clock_i);
		rd(ADDR_COUNT, 34'h8);
		boot(MODE_HOST_PORT, 16'd0);
		check("irq", cfg_irq_n_o, 1'b1);
		wr(ADDR_CTRL, 32'h9);
		repeat (3) @(posedge clock_i);
		check("irq", cfg_irq_n_o, 1'b0);
		check("user io", user_io_o, 5'h1e);
		tally_and_finish();
	end
endmodule : testbench
